/* File: tmr_timer16.sv */
// Purpose: 16-bit timer with two compare channels and one capture channel
// Assumes: classic wishbone slave, byte registers in bits 7:0 of each word
// Notes: one clock; pins pass two flip-flops before any logic reads them
//
// Summary of operation
// - with filter on, capture input changes only after four equal samples
// - edge select zero captures falling edges, one captures rising edges
// - capture copies the counter into the capture register and sets its flag
// - capture pin is ignored while the capture register is the top value
// - clock select: stop, undivided, or divided by 8, 64, 256, 1024
// - codes 110 and 111 count falling or rising edges of the count pin
// - count pin edges count whatever direction the pin has
// - high bytes pass one shared temporary byte for atomic access
// - a counter write blocks all compare matches on the next timer tick
// - both compare registers are compared with the counter on every timer tick
// - mask bits 7,6,5,3; request needs enable, global enable and flag
// - overflow flag in normal and clear-on-match modes at counter overflow
// - compare flag set in the tick after counter equals the compare value
// - a forced compare never sets a compare flag
// - flags clear on vector execution or on writing a one to them
// - with capture register as top, capture flag sets on reaching top
// - capture source is the pin or the analog comparator output
// - flags: overflow 7, compare a 6, compare b 5, capture 3, reset zero
// - four-bit waveform mode picks sequence and top; normal top is ffff
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
module tmr_timer16
    import tmr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_sel,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    input wire logic i_capture_pin,
    input wire logic i_acomp_out,
    input wire logic i_external_count_pin,
    input wire logic i_global_ie,
    input wire logic [3:0] i_vector_done,
    output logic [3:0] o_irq_req,
    output logic o_compare_output_a,
    output logic o_compare_output_b
);

    tmr_state_t s_ff;
    tmr_state_t nxt_s;

    logic req;
    logic wr;
    logic rd;
    logic [7:0] wdat;
    logic [3:0] wgm;
    logic [2:0] cs;
    logic [15:0] top;
    logic icr_top;
    logic cap_raw;
    logic cap_edge;
    logic cap_evt;
    logic ext_fall;
    logic ext_rise;
    logic tick;
    logic hit_a;
    logic hit_b;
    logic frc_a;
    logic frc_b;
    logic ovf;
    logic [7:0] set;
    logic [7:0] clr;

    function automatic logic is_dual(input logic [3:0] w);
        is_dual = w inside {W_PC8, W_PC9, W_PC10, W_PFC_ICR, W_PFC_OCRA,
                            W_PC_ICR, W_PC_OCRA};
    endfunction

    function automatic logic is_fast(input logic [3:0] w);
        is_fast = w inside {W_FAST8, W_FAST9, W_FAST10, W_FAST_ICR, W_FAST_OCRA};
    endfunction

    function automatic logic is_icr_top(input logic [3:0] w);
        is_icr_top = w inside {W_PFC_ICR, W_PC_ICR, W_CLR_ICR, W_FAST_ICR};
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0] w,
                                           input logic [15:0] a,
                                           input logic [15:0] c);
        case (w)
            W_PC8, W_FAST8: top_of = TOP_8;
            W_PC9, W_FAST9: top_of = TOP_9;
            W_PC10, W_FAST10: top_of = TOP_10;
            W_CLR_OCRA, W_PFC_OCRA, W_PC_OCRA, W_FAST_OCRA: top_of = a;
            W_CLR_ICR, W_PFC_ICR, W_PC_ICR, W_FAST_ICR: top_of = c;
            default: top_of = TOP_MAX;
        endcase
    endfunction

    function automatic logic presc_hit(input logic [9:0] p, input logic [9:0] m);
        presc_hit = (p & m) == m;
    endfunction

    always_comb begin
        nxt_s = s_ff;
        req = i_wb_cyc && i_wb_stb && !s_ff.ack;
        wr = req && i_wb_we && i_wb_sel[0];
        rd = req && !i_wb_we;
        wdat = i_wb_dat[7:0];
        wgm = {s_ff.ctrl_b[CB_WGM_HI:CB_WGM_LO], s_ff.ctrl_a[CA_WGM_HI:CA_WGM_LO]};
        cs = s_ff.ctrl_b[CB_CS_HI:CB_CS_LO];
        top = top_of(wgm, s_ff.ocra, s_ff.icr);
        icr_top = is_icr_top(wgm);

        // input synchronisers; stage 0 feeds stage 1 only
        nxt_s.cap_sync = {s_ff.cap_sync[0], i_capture_pin};
        nxt_s.acmp_sync = {s_ff.acmp_sync[0], i_acomp_out};
        nxt_s.ext_sync = {s_ff.ext_sync[0], i_external_count_pin};
        nxt_s.ext_prev = s_ff.ext_sync[1];

        // capture path
        cap_raw = s_ff.ctrl_a[CA_CAPSRC] ? s_ff.acmp_sync[1] : s_ff.cap_sync[1];
        nxt_s.nf_shift = {s_ff.nf_shift[NF_LEN-2:0], cap_raw};
        if (!s_ff.ctrl_b[CB_NF]) begin
            nxt_s.cap_filt = cap_raw;
        end else if (&s_ff.nf_shift) begin
            nxt_s.cap_filt = 1'b1;
        end else if (~|s_ff.nf_shift) begin
            nxt_s.cap_filt = 1'b0;
        end
        nxt_s.cap_prev = s_ff.cap_filt;
        cap_edge = (s_ff.cap_filt != s_ff.cap_prev) &&
                   (s_ff.cap_filt == s_ff.ctrl_b[CB_EDGE]);
        cap_evt = cap_edge && !icr_top;

        // timer tick; the count pin is read from its input path only, so an
        // output-configured pin still counts
        nxt_s.presc = s_ff.presc + ONE10;
        ext_fall = s_ff.ext_prev && !s_ff.ext_sync[1];
        ext_rise = !s_ff.ext_prev && s_ff.ext_sync[1];
        unique case (cs)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = presc_hit(s_ff.presc, PRE_M8);
            CS_DIV64: tick = presc_hit(s_ff.presc, PRE_M64);
            CS_DIV256: tick = presc_hit(s_ff.presc, PRE_M256);
            CS_DIV1024: tick = presc_hit(s_ff.presc, PRE_M1024);
            CS_EXT_FALL: tick = ext_fall;
            CS_EXT_RISE: tick = ext_rise;
        endcase

        // compare against the value the counter holds during this tick
        hit_a = tick && (s_ff.cnt == s_ff.ocra) && !s_ff.block;
        hit_b = tick && (s_ff.cnt == s_ff.ocrb) && !s_ff.block;
        frc_a = wr && (i_wb_adr == ADR_CTRL_A) && wdat[CA_FRC_A] &&
                !is_dual(wgm) && !is_fast(wgm);
        frc_b = wr && (i_wb_adr == ADR_CTRL_A) && wdat[CA_FRC_B] &&
                !is_dual(wgm) && !is_fast(wgm);
        nxt_s.match_a = hit_a || frc_a;
        nxt_s.match_b = hit_b || frc_b;

        // counting sequence
        ovf = 1'b0;
        if (tick) begin
            nxt_s.block = 1'b0;
            if (is_dual(wgm)) begin
                if (!s_ff.dir_down) begin
                    if (s_ff.cnt >= top) begin
                        nxt_s.dir_down = 1'b1;
                        nxt_s.cnt = s_ff.cnt - ONE16;
                    end else begin
                        nxt_s.cnt = s_ff.cnt + ONE16;
                    end
                end else if (s_ff.cnt == BOTTOM) begin
                    nxt_s.dir_down = 1'b0;
                    nxt_s.cnt = s_ff.cnt + ONE16;
                    ovf = 1'b1;
                end else begin
                    nxt_s.cnt = s_ff.cnt - ONE16;
                end
            end else if (s_ff.cnt == top) begin
                nxt_s.cnt = BOTTOM;
                ovf = is_fast(wgm) || (s_ff.cnt == TOP_MAX);
            end else begin
                nxt_s.cnt = s_ff.cnt + ONE16;
                ovf = s_ff.cnt == TOP_MAX;
            end
        end

        // capture register load
        if (cap_evt) begin
            nxt_s.icr = s_ff.cnt;
        end

        // flags: a set in the same cycle as a clear wins
        set = 8'h00;
        set[B_OVF] = ovf;
        set[B_CMPA] = hit_a;
        set[B_CMPB] = hit_b;
        set[B_CAP] = cap_evt || (icr_top && tick && (s_ff.cnt == top));
        clr = 8'h00;
        if (wr && (i_wb_adr == ADR_FLAGS)) begin
            clr = wdat & IRQ_BITS;
        end
        clr[B_OVF] = clr[B_OVF] | i_vector_done[IV_OVF];
        clr[B_CMPA] = clr[B_CMPA] | i_vector_done[IV_CMPA];
        clr[B_CMPB] = clr[B_CMPB] | i_vector_done[IV_CMPB];
        clr[B_CAP] = clr[B_CAP] | i_vector_done[IV_CAP];
        nxt_s.flags = ((s_ff.flags & ~clr) | set) & IRQ_BITS;

        // requests gated by enable, global enable and flag
        nxt_s.irq[IV_OVF] = s_ff.flags[B_OVF] && s_ff.mask[B_OVF] && i_global_ie;
        nxt_s.irq[IV_CMPA] = s_ff.flags[B_CMPA] && s_ff.mask[B_CMPA] && i_global_ie;
        nxt_s.irq[IV_CMPB] = s_ff.flags[B_CMPB] && s_ff.mask[B_CMPB] && i_global_ie;
        nxt_s.irq[IV_CAP] = s_ff.flags[B_CAP] && s_ff.mask[B_CAP] && i_global_ie;

        // register writes; a counter write overrides this cycle's count
        nxt_s.ack = req;
        if (wr) begin
            case (i_wb_adr)
                ADR_CTRL_A: nxt_s.ctrl_a = wdat & CTRL_A_WMASK;
                ADR_CTRL_B: nxt_s.ctrl_b = wdat & CTRL_B_WMASK;
                ADR_CNT_H, ADR_OCRA_H, ADR_OCRB_H, ADR_ICR_H: begin
                    nxt_s.temp = wdat;
                end
                ADR_CNT_L: begin
                    nxt_s.cnt = {s_ff.temp, wdat};
                    nxt_s.block = 1'b1;
                end
                ADR_OCRA_L: nxt_s.ocra = {s_ff.temp, wdat};
                ADR_OCRB_L: nxt_s.ocrb = {s_ff.temp, wdat};
                ADR_ICR_L: nxt_s.icr = {s_ff.temp, wdat};
                ADR_MASK: nxt_s.mask = wdat & IRQ_BITS;
                default: ;
            endcase
        end

        // register reads; a low byte read latches its high byte into temp
        if (rd) begin
            case (i_wb_adr)
                ADR_CTRL_A: nxt_s.rdat = s_ff.ctrl_a;
                ADR_CTRL_B: nxt_s.rdat = s_ff.ctrl_b;
                ADR_CNT_L: begin
                    nxt_s.rdat = s_ff.cnt[7:0];
                    nxt_s.temp = s_ff.cnt[15:8];
                end
                ADR_OCRA_L: begin
                    nxt_s.rdat = s_ff.ocra[7:0];
                    nxt_s.temp = s_ff.ocra[15:8];
                end
                ADR_OCRB_L: begin
                    nxt_s.rdat = s_ff.ocrb[7:0];
                    nxt_s.temp = s_ff.ocrb[15:8];
                end
                ADR_ICR_L: begin
                    nxt_s.rdat = s_ff.icr[7:0];
                    nxt_s.temp = s_ff.icr[15:8];
                end
                ADR_CNT_H, ADR_OCRA_H, ADR_OCRB_H, ADR_ICR_H: begin
                    nxt_s.rdat = s_ff.temp;
                end
                ADR_MASK: nxt_s.rdat = s_ff.mask;
                ADR_FLAGS: nxt_s.rdat = s_ff.flags;
                default: nxt_s.rdat = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_wb_ack = s_ff.ack;
    assign o_wb_dat = {RD_PAD, s_ff.rdat};
    assign o_irq_req = s_ff.irq;
    assign o_compare_output_a = s_ff.match_a;
    assign o_compare_output_b = s_ff.match_b;

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held more than one cycle");

    filter_steady_a: assert property (
        s_ff.ctrl_b[CB_NF] && $past(s_ff.ctrl_b[CB_NF]) && $changed(s_ff.cap_filt)
        |-> $past(&s_ff.nf_shift) || $past(~|s_ff.nf_shift))
        else $error("filtered capture changed without four equal samples");

    capture_copy_a: assert property (
        cap_evt |=> (s_ff.icr == $past(s_ff.cnt)) && s_ff.flags[B_CAP])
        else $error("capture did not copy counter or set flag");

    icr_top_block_a: assert property (
        icr_top && !(wr && i_wb_adr == ADR_ICR_L) |=> $stable(s_ff.icr))
        else $error("capture from pin while capture register is top");

    div8_tick_a: assert property (
        cs == CS_DIV8 && tick
        |=> (!tick || cs != CS_DIV8) [*7] ##1 (tick || cs != CS_DIV8))
        else $error("divide-by-8 tick misplaced");

    ext_rise_a: assert property (
        cs == CS_EXT_RISE && !s_ff.ext_prev && s_ff.ext_sync[1] |-> tick)
        else $error("rising count pin edge not counted");

    write_block_a: assert property (
        wr && i_wb_adr == ADR_CNT_L && cs == CS_DIV1 ##1 !s_ff.flags[B_CMPA]
        |=> !s_ff.flags[B_CMPA])
        else $error("compare match after counter write");

    cmp_flag_a: assert property (
        hit_a |=> s_ff.flags[B_CMPA])
        else $error("compare a flag not set after match");

    force_no_flag_a: assert property (
        frc_a && !hit_a && !s_ff.flags[B_CMPA] |=> !s_ff.flags[B_CMPA])
        else $error("forced compare set the flag");

    irq_gate_a: assert property (
        ##1 o_irq_req[IV_CAP] == $past(s_ff.flags[B_CAP] && s_ff.mask[B_CAP] && i_global_ie))
        else $error("capture request not gated correctly");

    w1c_clear_a: assert property (
        wr && i_wb_adr == ADR_FLAGS && wdat[B_OVF] && !ovf |=> !s_ff.flags[B_OVF])
        else $error("overflow flag not cleared by writing one");

    stop_hold_a: assert property (
        cs == CS_STOP && !wr |=> $stable(s_ff.cnt) && !$rose(s_ff.flags[B_OVF]))
        else $error("counter moved while stopped");

    ovf_normal_a: assert property (
        tick && !wr && wgm == W_NORMAL && s_ff.cnt == TOP_MAX
        |=> s_ff.flags[B_OVF] && s_ff.cnt == BOTTOM)
        else $error("normal mode wrap did not set overflow");

    vec_clear_a: assert property (
        i_vector_done[IV_CMPB] && !hit_b |=> !s_ff.flags[B_CMPB])
        else $error("vector execution did not clear compare b flag");

endmodule

/* File: tmr_pkg.sv */
// Purpose: constants and state type for the 16-bit capture/compare timer
// Assumes: byte-wide registers, each on its own 32-bit wishbone word
// Notes: byte address of every register is a multiple of four
package tmr_pkg;
    localparam logic [7:0] ADR_CTRL_A = 8'h00;
    localparam logic [7:0] ADR_CTRL_B = 8'h04;
    localparam logic [7:0] ADR_CNT_L = 8'h08;
    localparam logic [7:0] ADR_CNT_H = 8'h0c;
    localparam logic [7:0] ADR_OCRA_L = 8'h10;
    localparam logic [7:0] ADR_OCRA_H = 8'h14;
    localparam logic [7:0] ADR_OCRB_L = 8'h18;
    localparam logic [7:0] ADR_OCRB_H = 8'h1c;
    localparam logic [7:0] ADR_ICR_L = 8'h20;
    localparam logic [7:0] ADR_ICR_H = 8'h24;
    localparam logic [7:0] ADR_MASK = 8'h28;
    localparam logic [7:0] ADR_FLAGS = 8'h2c;

    // flag and mask bit positions
    localparam int B_OVF = 7;
    localparam int B_CMPA = 6;
    localparam int B_CMPB = 5;
    localparam int B_CAP = 3;
    localparam logic [7:0] IRQ_BITS = 8'he8;

    // interrupt request / vector-done order
    localparam int IV_OVF = 3;
    localparam int IV_CMPA = 2;
    localparam int IV_CMPB = 1;
    localparam int IV_CAP = 0;

    // control b fields
    localparam int CB_NF = 7;
    localparam int CB_EDGE = 6;
    localparam int CB_WGM_HI = 4;
    localparam int CB_WGM_LO = 3;
    localparam int CB_CS_HI = 2;
    localparam int CB_CS_LO = 0;
    localparam logic [7:0] CTRL_B_WMASK = 8'hdf;

    // control a fields
    localparam int CA_CAPSRC = 4;
    localparam int CA_FRC_A = 3;
    localparam int CA_FRC_B = 2;
    localparam int CA_WGM_HI = 1;
    localparam int CA_WGM_LO = 0;
    localparam logic [7:0] CTRL_A_WMASK = 8'h13;

    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    localparam logic [9:0] PRE_M8 = 10'h007;
    localparam logic [9:0] PRE_M64 = 10'h03f;
    localparam logic [9:0] PRE_M256 = 10'h0ff;
    localparam logic [9:0] PRE_M1024 = 10'h3ff;

    localparam logic [3:0] W_NORMAL = 4'h0;
    localparam logic [3:0] W_PC8 = 4'h1;
    localparam logic [3:0] W_PC9 = 4'h2;
    localparam logic [3:0] W_PC10 = 4'h3;
    localparam logic [3:0] W_CLR_OCRA = 4'h4;
    localparam logic [3:0] W_FAST8 = 4'h5;
    localparam logic [3:0] W_FAST9 = 4'h6;
    localparam logic [3:0] W_FAST10 = 4'h7;
    localparam logic [3:0] W_PFC_ICR = 4'h8;
    localparam logic [3:0] W_PFC_OCRA = 4'h9;
    localparam logic [3:0] W_PC_ICR = 4'ha;
    localparam logic [3:0] W_PC_OCRA = 4'hb;
    localparam logic [3:0] W_CLR_ICR = 4'hc;
    localparam logic [3:0] W_FAST_ICR = 4'he;
    localparam logic [3:0] W_FAST_OCRA = 4'hf;

    localparam logic [15:0] TOP_MAX = 16'hffff;
    localparam logic [15:0] TOP_8 = 16'h00ff;
    localparam logic [15:0] TOP_9 = 16'h01ff;
    localparam logic [15:0] TOP_10 = 16'h03ff;
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [9:0] ONE10 = 10'h001;
    localparam logic [23:0] RD_PAD = 24'h000000;
    localparam int NF_LEN = 4;

    typedef struct packed {
        logic ack;
        logic [7:0] rdat;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [15:0] cnt;
        logic [15:0] ocra;
        logic [15:0] ocrb;
        logic [15:0] icr;
        logic [7:0] temp;
        logic [7:0] mask;
        logic [7:0] flags;
        logic [9:0] presc;
        logic [1:0] cap_sync;
        logic [1:0] acmp_sync;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [NF_LEN-1:0] nf_shift;
        logic cap_filt;
        logic cap_prev;
        logic block;
        logic dir_down;
        logic [3:0] irq;
        logic match_a;
        logic match_b;
    } tmr_state_t;
endpackage

/* File: tmr_timer16_test.sv */
// Purpose: self-checking bench for the 16-bit capture/compare timer
// Assumes: byte registers on wishbone words, sel[0] always set, one clock
// Notes: counter values are only compared while the counter is stopped
`timescale 1ns/100ps
module tmr_timer16_test;
    import tmr_pkg::*;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [2:0] pins = 3'h0;
    logic ie = 1'b0;
    logic [3:0] vdone = 4'h0;
    logic ack;
    logic [31:0] rdat;
    logic [3:0] irq;
    logic oca;
    logic ocb;
    int na = 0;
    int nb = 0;
    int error_cnt = 0;
    int checked = 0;

    always #25 i_mclk = ~i_mclk;

    // compare output pulses, counted once reset is gone
    always @(posedge i_mclk) begin
        if (i_resetn) begin
            na <= na + oca;
            nb <= nb + ocb;
        end
    end

    tmr_timer16 i_dut (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_sel(4'h1), .i_wb_adr(adr), .i_wb_dat(wdat),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_capture_pin(pins[0]),
        .i_acomp_out(pins[1]), .i_external_count_pin(pins[2]),
        .i_global_ie(ie), .i_vector_done(vdone), .o_irq_req(irq),
        .o_compare_output_a(oca), .o_compare_output_b(ocb)
    );

    task automatic summarize;
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
        checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            error_cnt++;
            $display("ERROR %0t: count %h outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // one classic cycle; a missing ack ends the run
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        n = 0;
        @(posedge i_mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge i_mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            $display("ERROR %0t: no bus answer", $time);
            summarize();
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        wb(a, 1'b0, 8'h00, q);
    endtask

    // high byte goes first so the low write commits both halves
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a + 8'h04, d[15:8]);
        wr(a, d[7:0]);
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h04, v[15:8]);
    endtask

    task automatic flags_are(input logic [7:0] e);
        logic [7:0] q;
        rd(ADR_FLAGS, q);
        chk({8'h00, q}, {8'h00, e});
    endtask

    task automatic wait_irq(input int i);
        int n;
        n = 0;
        while (irq[i] !== 1'b1 && n < 3000) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 3000) begin
            error_cnt++;
            $display("ERROR %0t: request %0d never rose", $time, i);
            summarize();
        end
    endtask

    // pins pass synchronisers and the filter, so settle before reading
    task automatic setp(input int w, input logic v);
        @(posedge i_mclk);
        pins[w] <= v;
        repeat (14) @(posedge i_mclk);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            pins[2] <= 1'b1;
            repeat (4) @(posedge i_mclk);
            pins[2] <= 1'b0;
            repeat (3) @(posedge i_mclk);
        end
        repeat (8) @(posedge i_mclk);
    endtask

    task automatic vec(input logic [3:0] m);
        @(posedge i_mclk);
        vdone <= m;
        @(posedge i_mclk);
        vdone <= 4'h0;
    endtask

    initial begin
        logic [7:0] b;
        logic [15:0] v;
        int dv[5];
        dv = '{1, 8, 64, 256, 1024};
        repeat (20) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rd(ADR_MASK, b);
        chk({8'h00, b}, 16'h0000);
        flags_are(8'h00);
        rd16(ADR_OCRA_L, v);
        chk(v, 16'h0000);
        rd16(ADR_OCRB_L, v);
        chk(v, 16'h0000);
        rd(8'h30, b);
        chk({8'h00, b}, 16'h0000);
        wr(ADR_CTRL_B, 8'hdf);
        rd(ADR_CTRL_B, b);
        chk({8'h00, b}, 16'h00df);
        wr(ADR_CTRL_B, 8'h00);
        wr16(ADR_OCRA_L, 16'h1234);
        wr16(ADR_OCRB_L, 16'h5678);
        rd16(ADR_OCRA_L, v);
        chk(v, 16'h1234);
        rd16(ADR_OCRB_L, v);
        chk(v, 16'h5678);
        wr16(ADR_CNT_L, 16'h0100);
        repeat (20) @(posedge i_mclk);
        rd16(ADR_CNT_L, v);
        chk(v, 16'h0100);
        flags_are(8'h00);
        for (int k = 1; k <= 5; k++) begin
            wr16(ADR_CNT_L, 16'h0000);
            wr(ADR_CTRL_B, k[7:0]);
            repeat (2048) @(posedge i_mclk);
            wr(ADR_CTRL_B, 8'h00);
            rd16(ADR_CNT_L, v);
            chk_rng(v, 2048 / dv[k-1], 2048 / dv[k-1] + 4);
        end
        ie <= 1'b1;
        wr(ADR_MASK, 8'he8);
        wr16(ADR_OCRA_L, 16'h0110);
        wr16(ADR_CNT_L, 16'h0100);
        wr(ADR_CTRL_B, {5'h00, CS_DIV1});
        wait_irq(IV_CMPA);
        wr(ADR_CTRL_B, 8'h00);
        flags_are(8'h40);
        wr(ADR_FLAGS, 8'h40);
        flags_are(8'h00);
        chk({12'h000, irq}, 16'h0000);
        wr16(ADR_OCRB_L, 16'h0200);
        wr(ADR_CTRL_B, {5'h00, CS_DIV1});
        wr16(ADR_CNT_L, 16'h0200);
        wr(ADR_CTRL_B, 8'h00);
        flags_are(8'h00);
        wr(ADR_CTRL_B, {5'h00, CS_DIV1});
        wr16(ADR_CNT_L, 16'h01f0);
        wait_irq(IV_CMPB);
        vec(4'h2);
        wr16(ADR_CNT_L, 16'hfff0);
        wait_irq(IV_OVF);
        wr(ADR_CTRL_B, 8'h00);
        flags_are(8'h80);
        ie <= 1'b0;
        repeat (3) @(posedge i_mclk);
        chk({12'h000, irq}, 16'h0000);
        ie <= 1'b1;
        vec(4'h8);
        flags_are(8'h00);
        wr(ADR_CTRL_A, 8'h08);
        wr(ADR_CTRL_A, 8'h04);
        flags_are(8'h00);
        chk({na[7:0], nb[7:0]}, 16'h0202);
        wr16(ADR_CNT_L, 16'h0000);
        wr(ADR_CTRL_B, {5'h00, CS_EXT_RISE});
        pulses(5);
        wr(ADR_CTRL_B, {5'h00, CS_EXT_FALL});
        pulses(3);
        wr(ADR_CTRL_B, 8'h00);
        rd16(ADR_CNT_L, v);
        chk(v, 16'h0008);
        // capture on the chosen edge only
        wr16(ADR_CNT_L, 16'h4321);
        wr(ADR_CTRL_B, 8'h40);
        setp(0, 1'b1);
        flags_are(8'h08);
        rd16(ADR_ICR_L, v);
        chk(v, 16'h4321);
        wr(ADR_FLAGS, 8'h08);
        setp(0, 1'b0);
        flags_are(8'h00);
        wr(ADR_CTRL_B, 8'h00);
        wr16(ADR_CNT_L, 16'h0abc);
        setp(0, 1'b1);
        flags_are(8'h00);
        setp(0, 1'b0);
        flags_are(8'h08);
        rd16(ADR_ICR_L, v);
        chk(v, 16'h0abc);
        wr(ADR_FLAGS, 8'h08);
        // a three-cycle glitch must not pass the four-sample filter
        wr(ADR_CTRL_B, 8'hc0);
        @(posedge i_mclk);
        pins[0] <= 1'b1;
        repeat (3) @(posedge i_mclk);
        pins[0] <= 1'b0;
        repeat (14) @(posedge i_mclk);
        flags_are(8'h00);
        setp(0, 1'b1);
        flags_are(8'h08);
        wr(ADR_FLAGS, 8'h08);
        setp(0, 1'b0);
        wr(ADR_CTRL_A, 8'h10);
        wr(ADR_CTRL_B, 8'h40);
        setp(1, 1'b1);
        flags_are(8'h08);
        wr(ADR_FLAGS, 8'h08);
        wr(ADR_CTRL_A, 8'h00);
        wr16(ADR_ICR_L, 16'h0020);
        wr16(ADR_CNT_L, 16'h0010);
        wr(ADR_CTRL_B, 8'h58);
        setp(0, 1'b1);
        flags_are(8'h00);
        rd16(ADR_ICR_L, v);
        chk(v, 16'h0020);
        wr(ADR_CTRL_B, 8'h59);
        wait_irq(IV_CAP);
        wr(ADR_CTRL_B, 8'h00);
        flags_are(8'h08);
        // fast 8-bit mode wraps at its own top and flags overflow there
        wr(ADR_FLAGS, 8'h08);
        wr(ADR_CTRL_A, 8'h01);
        wr16(ADR_CNT_L, 16'h00f0);
        wr(ADR_CTRL_B, 8'h09);
        wait_irq(IV_OVF);
        wr(ADR_CTRL_B, 8'h00);
        flags_are(8'h80);
        rd16(ADR_CNT_L, v);
        chk_rng(v, 0, 16);
        summarize();
    end
endmodule
